// ==== verilog/jtr_test_data_regs.sv ====
// bypass, boundary scan and identification registers behind the test port
// What this block does
// - one-bit bypass for bypass, clamp, highz
// - boundary register: shift path plus parallel latch
// - identification: 32-bit shift and parallel latch
// - identification selected by idcode or reset state
// - id word: revision, device, maker, lsb one
// - bypass, boundary and identification all present
// - three-bit instruction codes decode register choice
// - idcode capture loads id, shift-dr shifts out
`timescale 1ns/1ns
module jtr_test_data_regs #(
  parameter int BSR_W = 16,
  parameter logic [3:0] ID_REVISION = 4'h0, // arbitrary value
  parameter logic [15:0] ID_DEVICE = 16'h0123, // arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h055 // arbitrary value
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic scan_test_clock_in,
  input wire logic scan_serial_in_in,
  input wire jtr_pkg::jtr_tap_state_t tap_state_in,
  input wire logic [jtr_pkg::INSTR_W-1:0] instr_in,
  input wire logic [BSR_W-1:0] io_sample_in,
  output logic scan_serial_out_out,
  output logic scan_serial_oe_n_out,
  output logic [BSR_W-1:0] bsr_par_out,
  output logic [jtr_pkg::ID_W-1:0] id_par_out,
  output logic io_ext_drive_out,
  output logic io_highz_out
);
  import jtr_pkg::*;

  // identification word
  localparam logic [ID_W-1:0] ID_VALUE = {ID_REVISION, ID_DEVICE, ID_MAKER, ID_FIXED_LSB};

  logic sck_s1_ff, sck_s2_ff, sck_s3_ff;
  logic tdi_s1_ff, tdi_s2_ff;
  logic [BSR_W-1:0] io_s1_ff, io_s2_ff;
  logic tck_rise, tck_fall;
  jtr_sel_t sel;
  jtr_ctl_t bsr_ctl, idr_ctl;
  logic byp_ff;
  logic [BSR_W-1:0] bsr_shift;
  logic [ID_W-1:0] idr_shift;
  logic serial_bit;
  logic scan_out_ff, scan_oe_n_ff, ext_drive_ff, highz_ff;

  // register choice from instruction and reset state
  function automatic jtr_sel_t pick_reg(input logic [INSTR_W-1:0] code, input logic in_reset);
    jtr_sel_t r;
    r = SEL_BYP;
    if (in_reset)
      r = SEL_IDR;
    else if (code == INSTR_IDCODE)
      r = SEL_IDR;
    else if ((code == INSTR_EXTEST) || (code == INSTR_SAMPLE))
      r = SEL_BSR;
    return r;
  endfunction : pick_reg

  // two-flop sync of test clock and serial input, third flop for edges
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sck_s1_ff <= 1'h0;
      sck_s2_ff <= 1'h0;
      sck_s3_ff <= 1'h0;
      tdi_s1_ff <= 1'h0;
      tdi_s2_ff <= 1'h0;
    end
    else
    begin
      sck_s1_ff <= scan_test_clock_in;
      sck_s2_ff <= sck_s1_ff;
      sck_s3_ff <= sck_s2_ff;
      tdi_s1_ff <= scan_serial_in_in;
      tdi_s2_ff <= tdi_s1_ff;
    end
  end

  assign tck_rise = sck_s2_ff & ~sck_s3_ff;
  assign tck_fall = ~sck_s2_ff & sck_s3_ff;

  // two-flop sync of io cell values before boundary capture
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      io_s1_ff <= '0;
      io_s2_ff <= '0;
    end
    else
    begin
      io_s1_ff <= io_sample_in;
      io_s2_ff <= io_s1_ff;
    end
  end

  // select and per-register controls
  assign sel = pick_reg(instr_in, tap_state_in == TAP_RESET);
  assign bsr_ctl.capture = tck_rise && (tap_state_in == TAP_CAP_DR) && (sel == SEL_BSR);
  assign bsr_ctl.shift = tck_rise && (tap_state_in == TAP_SHIFT_DR) && (sel == SEL_BSR);
  assign bsr_ctl.update = tck_fall && (tap_state_in == TAP_UPD_DR) && (sel == SEL_BSR);
  assign idr_ctl.capture = tck_rise && (tap_state_in == TAP_CAP_DR) && (sel == SEL_IDR);
  assign idr_ctl.shift = tck_rise && (tap_state_in == TAP_SHIFT_DR) && (sel == SEL_IDR);
  assign idr_ctl.update = tck_fall && (tap_state_in == TAP_UPD_DR) && (sel == SEL_IDR);

  // bypass stage: captures zero, then passes serial input
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      byp_ff <= BYP_RST;
    else if (tck_rise && (sel == SEL_BYP) && (tap_state_in == TAP_CAP_DR))
      byp_ff <= BYP_CAPTURE;
    else if (tck_rise && (sel == SEL_BYP) && (tap_state_in == TAP_SHIFT_DR))
      byp_ff <= tdi_s2_ff;
  end

  // boundary scan register over all control and io cells
  jtr_scan_reg #(
    .WIDTH(BSR_W),
    .PAR_RST('0)
  ) u_bsr (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .ctl_in(bsr_ctl),
    .serial_in(tdi_s2_ff),
    .cap_val_in(io_s2_ff),
    .shift_q_out(bsr_shift),
    .par_q_out(bsr_par_out)
  );

  // identification register, parallel side resets to the id word and loads shifted data on update
  jtr_scan_reg #(
    .WIDTH(ID_W),
    .PAR_RST(ID_VALUE)
  ) u_idr (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .ctl_in(idr_ctl),
    .serial_in(tdi_s2_ff),
    .cap_val_in(ID_VALUE),
    .shift_q_out(idr_shift),
    .par_q_out(id_par_out)
  );

  // serial bit of the register in the path, lsb first
  always_comb
  begin
    serial_bit = byp_ff; // unused select code falls back to bypass
    unique case (sel)
      SEL_BYP: serial_bit = byp_ff;
      SEL_BSR: serial_bit = bsr_shift[0];
      SEL_IDR: serial_bit = idr_shift[0];
    endcase
  end

  // serial output changes on the falling test clock edge
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      scan_out_ff <= TDO_RST;
      scan_oe_n_ff <= TDO_OE_N_RST;
    end
    else if (tck_fall)
    begin
      scan_out_ff <= serial_bit;
      scan_oe_n_ff <= (tap_state_in != TAP_SHIFT_DR);
    end
  end

  // io cell modes from the current instruction
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ext_drive_ff <= 1'h0;
      highz_ff <= 1'h0;
    end
    else
    begin
      ext_drive_ff <= (tap_state_in != TAP_RESET) && ((instr_in == INSTR_EXTEST) || (instr_in == INSTR_CLAMP));
      highz_ff <= (tap_state_in != TAP_RESET) && (instr_in == INSTR_HIGHZ);
    end
  end

  assign scan_serial_out_out = scan_out_ff;
  assign scan_serial_oe_n_out = scan_oe_n_ff;
  assign io_ext_drive_out = ext_drive_ff;
  assign io_highz_out = highz_ff;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);

  // bypass loads zero on capture
  a_bypass_capture: assert property (
    tck_rise && (tap_state_in == TAP_CAP_DR) && (sel == SEL_BYP) |=> (byp_ff == 1'h0))
    else $error("bypass capture not zero");

  // bypass passes serial input in one stage
  a_bypass_path: assert property (
    tck_rise && (tap_state_in == TAP_SHIFT_DR) && (sel == SEL_BYP) |=> (byp_ff == $past(tdi_s2_ff)))
    else $error("bypass shift wrong");

  // boundary capture samples io cells
  a_bsr_capture: assert property (
    bsr_ctl.capture |=> (bsr_shift == $past(io_s2_ff)))
    else $error("boundary capture wrong");

  // boundary parallel latch moves only on update
  a_bsr_latch: assert property (
    !bsr_ctl.update |=> $stable(bsr_par_out))
    else $error("boundary latch changed without update");

  // reset state picks identification
  a_reset_select: assert property (
    (tap_state_in == TAP_RESET) |-> (sel == SEL_IDR))
    else $error("reset state not on identification");

  // instruction decode to register
  a_instr_decode: assert property (
    (tap_state_in != TAP_RESET) && ((instr_in == INSTR_CLAMP) || (instr_in == INSTR_HIGHZ)
      || (instr_in == INSTR_BYPASS)) |-> (sel == SEL_BYP))
    else $error("bypass-class code not on bypass");

  // idcode capture loads the id word, lsb one
  a_id_capture: assert property (
    idr_ctl.capture |=> (idr_shift == ID_VALUE) && (idr_shift[0] == 1'h1))
    else $error("id capture wrong");

  // id shifts toward bit 0
  a_id_lsb_first: assert property (
    idr_ctl.shift |=> (idr_shift == {$past(tdi_s2_ff), $past(idr_shift[ID_W-1:1])}))
    else $error("id shift order wrong");

  // serial out follows the selected bit on the falling edge
  a_serial_out: assert property (
    tck_fall |=> (scan_serial_out_out == $past(serial_bit)))
    else $error("serial out wrong");

endmodule : jtr_test_data_regs

// ==== verilog/jtr_pkg.sv ====
// shared constants and types for the scan test data registers
package jtr_pkg;

  // instruction codes, three bits wide
  localparam int INSTR_W = 3;
  localparam logic [INSTR_W-1:0] INSTR_EXTEST = 3'h0;
  localparam logic [INSTR_W-1:0] INSTR_IDCODE = 3'h1;
  localparam logic [INSTR_W-1:0] INSTR_SAMPLE = 3'h2;
  localparam logic [INSTR_W-1:0] INSTR_CLAMP = 3'h3;
  localparam logic [INSTR_W-1:0] INSTR_HIGHZ = 3'h4;
  localparam logic [INSTR_W-1:0] INSTR_BYPASS = 3'h7;

  // identification word layout
  localparam int ID_W = 32;
  localparam int ID_REV_W = 4;
  localparam int ID_REV_LSB = 28;
  localparam int ID_DEV_W = 16;
  localparam int ID_DEV_LSB = 12;
  localparam int ID_MFR_W = 11;
  localparam int ID_MFR_LSB = 1;
  localparam logic ID_FIXED_LSB = 1'h1;

  // reset and capture values
  localparam logic BYP_RST = 1'h0;
  localparam logic BYP_CAPTURE = 1'h0;
  localparam logic TDO_RST = 1'h0;
  localparam logic TDO_OE_N_RST = 1'h1;

  // tap controller states, driven by the controller elsewhere
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jtr_tap_state_t;

  // which data register sits in the serial path
  typedef enum logic [1:0] {SEL_BYP, SEL_BSR, SEL_IDR} jtr_sel_t;

  // one-cycle controls for a scan register
  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
  } jtr_ctl_t;

endpackage : jtr_pkg

// ==== verilog/jtr_scan_reg.sv ====
// shift stage plus latched parallel output of one scan register
`timescale 1ns/1ns
module jtr_scan_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] PAR_RST = '0
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire jtr_pkg::jtr_ctl_t ctl_in,
  input wire logic serial_in,
  input wire logic [WIDTH-1:0] cap_val_in,
  output logic [WIDTH-1:0] shift_q_out,
  output logic [WIDTH-1:0] par_q_out
);
  import jtr_pkg::*;

  logic [WIDTH-1:0] shift_ff;
  logic [WIDTH-1:0] par_ff;

  // capture loads in parallel, shift moves toward bit 0
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      shift_ff <= '0;
    else if (ctl_in.capture)
      shift_ff <= cap_val_in;
    else if (ctl_in.shift)
      shift_ff <= {serial_in, shift_ff[WIDTH-1:1]};
  end

  // parallel latch only follows on update
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      par_ff <= PAR_RST;
    else if (ctl_in.update)
      par_ff <= shift_ff;
  end

  assign shift_q_out = shift_ff;
  assign par_q_out = par_ff;

endmodule : jtr_scan_reg

// ==== dv/jtr_scan_partner.sv ====
// behavioural scan controller driving the test port pins
`timescale 1ns/1ns
module jtr_scan_partner (
  input wire logic clk_sys_in,
  output logic tck_out,
  output logic tdi_out,
  output jtr_pkg::jtr_tap_state_t state_out,
  output logic [jtr_pkg::INSTR_W-1:0] instr_out
);
  import jtr_pkg::*;
  // test clock stands low outside frames
  initial
  begin
    tck_out = 1'h0;
    tdi_out = 1'h0;
    state_out = TAP_RESET;
    instr_out = INSTR_IDCODE;
  end
  // one test clock period; state held until the fall is seen
  task automatic tick(input jtr_tap_state_t st, input logic d);
    @(posedge clk_sys_in);
    state_out <= st;
    tdi_out <= d;
    repeat (3) @(posedge clk_sys_in);
    tck_out <= 1'h1;
    repeat (4) @(posedge clk_sys_in);
    tck_out <= 1'h0;
    tdi_out <= ~d; // hold over, data no longer valid
    repeat (6) @(posedge clk_sys_in);
  endtask : tick
  // current instruction code
  task automatic load(input logic [INSTR_W-1:0] code);
    @(posedge clk_sys_in);
    instr_out <= code;
  endtask : load
endmodule : jtr_scan_partner

// ==== dv/jtr_test_data_regs_test.sv ====
// self-checking bench for the scan test data registers
`timescale 1ns/1ns
module jtr_test_data_regs_test;
  import jtr_pkg::*;
  localparam logic [3:0] REV = 4'h0; // arbitrary value
  localparam logic [15:0] DEV = 16'h0123; // arbitrary value
  localparam logic [10:0] MAKER = 11'h055; // arbitrary value
  localparam logic [31:0] ID_WORD = {REV, DEV, MAKER, ID_FIXED_LSB};
  logic clk_sys_in = 1'h0;
  logic arst_n_in = 1'h0;
  logic tck, tdi, tdo, oe_n, ext, hz;
  jtr_tap_state_t st;
  logic [2:0] instr;
  logic [15:0] io_samp = 16'h0000;
  logic [15:0] bsr_par;
  logic [31:0] id_par;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  // 20 MHz clock
  always #25 clk_sys_in = ~clk_sys_in;
  jtr_scan_partner i_jtr_scan_partner (.clk_sys_in(clk_sys_in), .tck_out(tck), .tdi_out(tdi),
    .state_out(st), .instr_out(instr));
  jtr_test_data_regs #(.BSR_W(16), .ID_REVISION(REV), .ID_DEVICE(DEV), .ID_MAKER(MAKER))
    i_jtr_test_data_regs (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .scan_test_clock_in(tck),
    .scan_serial_in_in(tdi), .tap_state_in(st), .instr_in(instr), .io_sample_in(io_samp),
    .scan_serial_out_out(tdo), .scan_serial_oe_n_out(oe_n), .bsr_par_out(bsr_par),
    .id_par_out(id_par), .io_ext_drive_out(ext), .io_highz_out(hz));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // capture, shift n bits reading serial out, exit and update
  task automatic dr_scan(input logic [2:0] code, input int n, input logic [31:0] exp,
    input logic [31:0] din);
    i_jtr_scan_partner.load(code);
    i_jtr_scan_partner.tick(TAP_CAP_DR, 1'h0);
    for (int i = 0; i < n; i++)
    begin
      chk(tdo, exp[i], "serial out");
      i_jtr_scan_partner.tick(TAP_SHIFT_DR, din[i]);
      chk(oe_n, 1'h0, "out enable");
    end
    i_jtr_scan_partner.tick(TAP_EXIT1_DR, 1'h0);
    chk(oe_n, 1'h1, "out disable");
    i_jtr_scan_partner.tick(TAP_UPD_DR, 1'h0);
  endtask : dr_scan
  task automatic test_reset;
    chk(id_par, ID_WORD, "id latch");
    chk(oe_n, TDO_OE_N_RST, "oe idle");
    chk(bsr_par, 16'h0000, "bsr latch");
    chk({ext, hz}, 2'h0, "io modes");
    $display("test reset done");
  endtask : test_reset
  // reset in mid-run restores latches and serial out
  task automatic test_mid_reset;
    arst_n_in <= 1'h0;
    repeat (2) @(posedge clk_sys_in);
    chk(id_par, ID_WORD, "id latch reset");
    chk(bsr_par, 16'h0000, "bsr latch reset");
    chk(oe_n, TDO_OE_N_RST, "oe reset");
    arst_n_in <= 1'h1;
    repeat (2) @(posedge clk_sys_in);
    chk(tdo, TDO_RST, "serial out reset");
    chk({ext, hz}, 2'h0, "modes reset");
    $display("test mid reset done");
  endtask : test_mid_reset
  task automatic test_idcode;
    dr_scan(INSTR_IDCODE, 32, ID_WORD, 32'h6B3D_21C4);
    chk(id_par, 32'h6B3D_21C4, "id latch update");
    $display("test idcode done");
  endtask : test_idcode
  task automatic test_bypass;
    logic [2:0] codes [5] = '{INSTR_BYPASS, INSTR_CLAMP, INSTR_HIGHZ, 3'h5, 3'h6};
    foreach (codes[k])
    begin
      dr_scan(codes[k], 5, 32'h0000_0016, 32'h0000_000B);
      chk(ext, codes[k] == INSTR_CLAMP, "clamp drive");
      chk(hz, codes[k] == INSTR_HIGHZ, "high impedance");
    end
    $display("test bypass done");
  endtask : test_bypass
  task automatic test_boundary;
    io_samp <= 16'hA5C3;
    dr_scan(INSTR_SAMPLE, 16, 32'h0000_A5C3, 32'h0000_3C96);
    chk(bsr_par, 16'h3C96, "bsr latch");
    chk(ext, 1'h0, "sample drive");
    dr_scan(INSTR_EXTEST, 16, 32'h0000_A5C3, 32'h0000_5A0F);
    chk(bsr_par, 16'h5A0F, "bsr latch");
    chk(ext, 1'h1, "extest drive");
    i_jtr_scan_partner.tick(TAP_RESET, 1'h0);
    chk({ext, hz}, 2'h0, "reset modes");
    $display("test boundary done");
  endtask : test_boundary
  // counts and verdict
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys_in);
    arst_n_in <= 1'h1;
    test_reset();
    test_idcode();
    test_bypass();
    test_boundary();
    test_mid_reset();
    end_sim();
  end
  // hang guard
  always @(posedge clk_sys_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      n_mismatch++;
      $display("unexpected at %0t: run timed out", $time);
      end_sim();
    end
  end
endmodule : jtr_test_data_regs_test
